//--- verilog/sltpg_cfg.svh
// Constants for the serial link test pattern generator
// What this block does
// - Long transport pattern is used when the transport test pattern is selected and the format has sixteen bits per sample.
// - Pattern length is K times ceil((M*S+2)/K) frames, then it repeats.
// - Link A and link B carry the identical long transport pattern.
// - Frame 0: every sample holds its converter index plus one.
// - Converter index counts per link, channel then I before Q; two links except format 15.
// - Format 15 single link: A-I 0, A-Q 1, B-I 2, B-Q 3.
// - Frame 1: every sample holds its sample index within the frame plus one.
// - Frame 2 onward: every sample holds two to the power N minus one.
// - With control bits, frame i below M*S sets only sample i mod S of converter i/S.
// - From frame M*S to pattern end all control bits are zero.
// - Pattern starts right after the alignment sequence and repeats while the link runs.
// - D21.5 mode sends an unbroken D21.5 stream on every lane.
// - K28.5 mode sends an unbroken K28.5 stream on every lane.
// - Repeated alignment mode resends the alignment sequence forever, never entering data phase.
// - In that mode a sync request triggers code group sync, then alignment resumes.
// - Modified RPAT mode repeats twelve fixed octets through the 8b/10b encoder.
`ifndef SLTPG_CFG_SVH
`define SLTPG_CFG_SVH

`define SLTPG_SEL_W        4
`define SLTPG_FMT_W        5
`define SLTPG_CONV_MAX     4
`define SLTPG_SMP_MAX      4
`define SLTPG_WORD_W       16
`define SLTPG_FRAME_W      256
`define SLTPG_FIDX_W       8
`define SLTPG_NP_LONG      5'h10
`define SLTPG_FMT_ONE_LINK 5'h0f

`define SLTPG_SEL_NONE     4'h0
`define SLTPG_SEL_TRANSP   4'h1
`define SLTPG_SEL_D215     4'h4
`define SLTPG_SEL_K285     4'h5
`define SLTPG_SEL_ILA_RPT  4'h6
`define SLTPG_SEL_RPAT     4'h7

`define SLTPG_CHAR_D215    8'hb5
`define SLTPG_CHAR_K285    8'hbc
`define SLTPG_RPAT_LEN     4'hc
`define SLTPG_RPAT_LAST    4'hb
`define SLTPG_RPAT_TABLE   96'hbed723476b8fb3145efb3559

`endif

//--- verilog/sltpg_pkg.sv
// Types shared by the test pattern generator modules
package sltpg_pkg;

  typedef enum logic [4:0] {
    SLTPG_MODE_NONE    = 5'b00001,
    SLTPG_MODE_TRANSP  = 5'b00010,
    SLTPG_MODE_CHAR    = 5'b00100,
    SLTPG_MODE_ILA_RPT = 5'b01000,
    SLTPG_MODE_RPAT    = 5'b10000
  } sltpg_mode_t;

  typedef enum logic [2:0] {
    SLTPG_ILA_OFF  = 3'b001,
    SLTPG_ILA_CGS  = 3'b010,
    SLTPG_ILA_SEND = 3'b100
  } sltpg_ila_st_t;

endpackage

//--- verilog/sltpg_frame_if.sv
// Carrier between the mode control and the long pattern frame builder
`timescale 1ns/10ps
`include "sltpg_cfg.svh"
interface sltpg_frame_if;
  logic [2:0]                 cfg_m;
  logic [2:0]                 cfg_s;
  logic [5:0]                 cfg_k;
  logic [4:0]                 cfg_n;
  logic                       cfg_cs;
  logic                       run;
  logic                       restart;
  logic [`SLTPG_FRAME_W-1:0]  frame;
  logic [`SLTPG_FIDX_W-1:0]   frame_idx;

  modport gen  (input cfg_m, cfg_s, cfg_k, cfg_n, cfg_cs, run, restart, output frame, frame_idx);
  modport user (output cfg_m, cfg_s, cfg_k, cfg_n, cfg_cs, run, restart, input frame, frame_idx);
endinterface

//--- verilog/sltpg_long_gen.sv
// Long transport test pattern frame builder
`timescale 1ns/10ps
`include "sltpg_cfg.svh"
module sltpg_long_gen
  import sltpg_pkg::*;
(
  input  wire logic    clk_sys_i,
  input  wire logic    rst_b_i,
  sltpg_frame_if.gen   fif
);

  logic [`SLTPG_FIDX_W-1:0] frm_q;
  logic [`SLTPG_FIDX_W-1:0] len_q;
  logic [`SLTPG_FIDX_W-1:0] len_d;
  logic [`SLTPG_FIDX_W-1:0] ms;
  logic [`SLTPG_FIDX_W-1:0] kk;

  // One sample word: data in the top N bits, control bit just below
  function automatic logic [15:0] smp_word(input logic [7:0] frm, input logic [7:0] ms_v,
                                           input logic [2:0] s_v, input logic [4:0] n_v,
                                           input logic cs_v, input logic [2:0] c, input logic [2:0] s);
    logic [15:0] val;
    logic [15:0] w;
    logic [7:0]  pos;
    val = 16'h0000;
    pos = 8'(c) * 8'(s_v) + 8'(s);
    if (frm == 8'h00) begin
      val = 16'(c) + 16'h0001;
    end else if (frm == 8'h01) begin
      val = 16'(s) + 16'h0001;
    end else begin
      val = 16'h0001 << (n_v - 5'h01);
    end
    w = val << (5'h10 - n_v);
    // Walking control bit, cleared once the walk is over
    if (cs_v && (n_v < 5'h10) && (frm < ms_v) && (pos == frm)) begin
      w = w | (16'h8000 >> n_v);
    end
    return w;
  endfunction

  // Pattern length: next multiple of K at or above M*S+2
  always_comb begin
    ms    = 8'(fif.cfg_m) * 8'(fif.cfg_s);
    kk    = (fif.cfg_k == 6'h00) ? 8'h01 : 8'(fif.cfg_k);
    len_d = 8'(((ms + 8'h02 + kk - 8'h01) / kk) * kk);
  end

  // Length is frozen at each restart so a stray config change cannot tear a pass
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      len_q <= 8'h02;
    end else if (fif.restart) begin
      len_q <= len_d;
    end
  end

  // Frame index, wraps at the pattern end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frm_q <= 8'h00;
    end else if (fif.restart) begin
      frm_q <= 8'h00;
    end else if (fif.run) begin
      frm_q <= (frm_q >= len_q - 8'h01) ? 8'h00 : frm_q + 8'h01;
    end
  end

  assign fif.frame_idx = frm_q;

  // Build every converter and sample slot; unused slots stay zero
  for (genvar c = 0; c < `SLTPG_CONV_MAX; c++) begin : g_conv
    for (genvar s = 0; s < `SLTPG_SMP_MAX; s++) begin : g_smp
      assign fif.frame[(c*`SLTPG_SMP_MAX+s)*16 +: 16] =
        ((3'(c) < fif.cfg_m) && (3'(s) < fif.cfg_s)) ?
        smp_word(frm_q, ms, fif.cfg_s, fif.cfg_n, fif.cfg_cs, 3'(c), 3'(s)) : 16'h0000;
    end
  end

endmodule

//--- verilog/sltpg_top.sv
// Test pattern insertion between transport and link layers of the serial output
`timescale 1ns/10ps
`include "sltpg_cfg.svh"
module sltpg_top
  import sltpg_pkg::*;
(
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_b_i,
  input  wire logic [`SLTPG_SEL_W-1:0]    link_test_pattern_select_i,
  input  wire logic [`SLTPG_FMT_W-1:0]    link_format_select_i,
  input  wire logic [4:0]                 cfg_np_i,
  input  wire logic [2:0]                 cfg_m_i,
  input  wire logic [2:0]                 cfg_s_i,
  input  wire logic [5:0]                 cfg_k_i,
  input  wire logic [4:0]                 cfg_n_i,
  input  wire logic                       cfg_cs_i,
  input  wire logic                       link_running_i,
  input  wire logic                       ilas_done_i,
  input  wire logic                       cgs_done_i,
  input  wire logic                       sync_b_i,
  input  wire logic [`SLTPG_FRAME_W-1:0]  data_a_i,
  input  wire logic [`SLTPG_FRAME_W-1:0]  data_b_i,
  output logic      [`SLTPG_FRAME_W-1:0]  frame_a_o,
  output logic      [`SLTPG_FRAME_W-1:0]  frame_b_o,
  output logic                            frame_valid_o,
  output logic                            pattern_start_o,
  output logic                            single_link_o,
  output logic      [7:0]                 char_o,
  output logic                            char_k_o,
  output logic                            char_sel_o,
  output logic                            data_phase_en_o,
  output logic                            cgs_req_o,
  output logic                            ilas_restart_o
);

  sltpg_frame_if fif ();

  logic          rst_m_q;
  logic          rst_s_q;
  logic          syn1_q;
  logic          syn2_q;
  logic          syn3_q;
  logic          sync_lvl_q;
  logic          dphase_q;
  logic [3:0]    rp_q;
  sltpg_mode_t   mode;
  sltpg_ila_st_t ila_q;
  sltpg_ila_st_t ila_d;
  logic          long_act;
  logic          sync_req;
  logic [7:0]    char_d;
  logic          k_d;

  // Selection decode, used by several processes
  function automatic sltpg_mode_t dec_mode(input logic [3:0] sel);
    sltpg_mode_t m;
    case (sel)
      `SLTPG_SEL_TRANSP:  m = SLTPG_MODE_TRANSP;
      `SLTPG_SEL_D215:    m = SLTPG_MODE_CHAR;
      `SLTPG_SEL_K285:    m = SLTPG_MODE_CHAR;
      `SLTPG_SEL_ILA_RPT: m = SLTPG_MODE_ILA_RPT;
      `SLTPG_SEL_RPAT:    m = SLTPG_MODE_RPAT;
      default:            m = SLTPG_MODE_NONE;
    endcase
    return m;
  endfunction

  // Selection is expected to be static while the link is disabled
  assign mode     = dec_mode(link_test_pattern_select_i);
  assign long_act = (mode == SLTPG_MODE_TRANSP) && (cfg_np_i == `SLTPG_NP_LONG);
  assign sync_req = !sync_lvl_q;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // Sync request pin: three flops, accepted once the last two agree
  always_ff @(posedge clk_sys_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      syn1_q     <= 1'b1;
      syn2_q     <= 1'b1;
      syn3_q     <= 1'b1;
      sync_lvl_q <= 1'b1;
    end else begin
      syn1_q <= sync_b_i;
      syn2_q <= syn1_q;
      syn3_q <= syn2_q;
      if (syn2_q == syn3_q) begin
        sync_lvl_q <= syn3_q;
      end
    end
  end

  // Data phase: entered at the end of alignment, left when the link stops
  always_ff @(posedge clk_sys_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      dphase_q <= 1'b0;
    end else if (!link_running_i || mode == SLTPG_MODE_ILA_RPT) begin
      dphase_q <= 1'b0;
    end else if (ilas_done_i) begin
      dphase_q <= 1'b1;
    end
  end

  // Frame builder is driven only while the long pattern is live
  assign fif.cfg_m   = cfg_m_i;
  assign fif.cfg_s   = cfg_s_i;
  assign fif.cfg_k   = cfg_k_i;
  assign fif.cfg_n   = cfg_n_i;
  assign fif.cfg_cs  = cfg_cs_i;
  assign fif.run     = long_act && dphase_q;
  assign fif.restart = !dphase_q;

  sltpg_long_gen u_long_gen (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_s_q),
    .fif       (fif)
  );

  // Frame outputs: both links get the same pattern, else pass-through
  always_ff @(posedge clk_sys_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      frame_a_o       <= '0;
      frame_b_o       <= '0;
      frame_valid_o   <= 1'b0;
      pattern_start_o <= 1'b0;
    end else begin
      frame_valid_o   <= dphase_q;
      pattern_start_o <= fif.run && (fif.frame_idx == 8'h00);
      if (long_act) begin
        frame_a_o <= fif.frame;
        frame_b_o <= fif.frame;
      end else begin
        frame_a_o <= data_a_i;
        frame_b_o <= data_b_i;
      end
    end
  end

  // Single link only in the one format that folds both channels together
  always_ff @(posedge clk_sys_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      single_link_o <= 1'b0;
    end else begin
      single_link_o <= (link_format_select_i == `SLTPG_FMT_ONE_LINK);
    end
  end

  // RPAT octet pointer; free running so the stream never breaks
  always_ff @(posedge clk_sys_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      rp_q <= 4'h0;
    end else if (mode != SLTPG_MODE_RPAT) begin
      rp_q <= 4'h0;
    end else begin
      rp_q <= (rp_q == `SLTPG_RPAT_LAST) ? 4'h0 : rp_q + 4'h1;
    end
  end

  // Octet choice for the character modes
  always_comb begin
    logic [95:0] tbl;
    tbl    = `SLTPG_RPAT_TABLE;
    char_d = 8'h00;
    k_d    = 1'b0;
    if (link_test_pattern_select_i == `SLTPG_SEL_D215) begin
      char_d = `SLTPG_CHAR_D215;
    end else if (link_test_pattern_select_i == `SLTPG_SEL_K285) begin
      char_d = `SLTPG_CHAR_K285;
      k_d    = 1'b1;
    end else if (mode == SLTPG_MODE_RPAT) begin
      char_d = tbl[8'd95 - 8'(rp_q) * 8'd8 -: 8];
    end
  end

  // Character outputs; lanes take these instead of frame data while selected
  always_ff @(posedge clk_sys_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      char_o     <= 8'h00;
      char_k_o   <= 1'b0;
      char_sel_o <= 1'b0;
    end else begin
      char_o     <= char_d;
      char_k_o   <= k_d;
      char_sel_o <= (mode == SLTPG_MODE_CHAR) || (mode == SLTPG_MODE_RPAT);
    end
  end

  // Repeated alignment sequencing
  always_comb begin
    ila_d = ila_q;
    case (ila_q)
      SLTPG_ILA_OFF: begin
        if (mode == SLTPG_MODE_ILA_RPT && link_running_i) begin
          ila_d = SLTPG_ILA_CGS;
        end
      end
      SLTPG_ILA_CGS: begin
        if (mode != SLTPG_MODE_ILA_RPT || !link_running_i) begin
          ila_d = SLTPG_ILA_OFF;
        end else if (!sync_req && cgs_done_i) begin
          ila_d = SLTPG_ILA_SEND;
        end
      end
      SLTPG_ILA_SEND: begin
        if (mode != SLTPG_MODE_ILA_RPT || !link_running_i) begin
          ila_d = SLTPG_ILA_OFF;
        end else if (sync_req) begin
          ila_d = SLTPG_ILA_CGS;
        end
      end
      default: ila_d = SLTPG_ILA_OFF;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      ila_q <= SLTPG_ILA_OFF;
    end else begin
      ila_q <= ila_d;
    end
  end

  // Link layer controls: alignment restarts after each pass instead of data
  always_ff @(posedge clk_sys_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      cgs_req_o       <= 1'b0;
      ilas_restart_o  <= 1'b0;
      data_phase_en_o <= 1'b0;
    end else begin
      cgs_req_o       <= (ila_d == SLTPG_ILA_CGS);
      ilas_restart_o  <= (ila_q == SLTPG_ILA_SEND) && ilas_done_i && !sync_req;
      data_phase_en_o <= (mode != SLTPG_MODE_ILA_RPT);
    end
  end

endmodule

//--- tb/sltpg_monitor.sv
// Port-level assertions for the test pattern generator
`timescale 1ns/10ps
module sltpg_monitor (
  input wire logic         clk_sys_i,
  input wire logic         rst_b_i,
  input wire logic [3:0]   link_test_pattern_select_i,
  input wire logic [4:0]   cfg_np_i,
  input wire logic [4:0]   cfg_n_i,
  input wire logic         link_running_i,
  input wire logic         ilas_done_i,
  input wire logic         sync_b_i,
  input wire logic [255:0] data_a_i,
  input wire logic [255:0] frame_a_o,
  input wire logic [255:0] frame_b_o,
  input wire logic         frame_valid_o,
  input wire logic         pattern_start_o,
  input wire logic [7:0]   char_o,
  input wire logic         char_k_o,
  input wire logic         data_phase_en_o,
  input wire logic         cgs_req_o
);
  logic [2:0]  up_q;
  logic        up;
  logic [3:0]  sel;
  logic        long_on;
  logic [15:0] w0;
  // Internal reset copy lags the pin, so hold checks off a few edges
  assign up = &up_q;
  assign sel = link_test_pattern_select_i;
  assign long_on = sel == 4'h1 && cfg_np_i == 5'h10;
  assign w0 = frame_a_o[15:0] >> (5'h10 - cfg_n_i);
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i)
      up_q <= 3'h0;
    else if (!up)
      up_q <= up_q + 3'h1;
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // Pattern frame 0 on the outputs while the link keeps running
  sequence s_pat_start;
    pattern_start_o && link_running_i && long_on;
  endsequence
  sequence s_rpat_enter;
    up && sel == 4'h7 && $past(sel) != 4'h7;
  endsequence
  a_pass_through: assert property (
    $past(up && sel == 4'h0) && $past(sel == 4'h0, 2) |-> frame_a_o == $past(data_a_i))
    else $error("pass-through data differs");
  a_links_same: assert property (frame_valid_o && long_on |-> frame_b_o == frame_a_o)
    else $error("links differ in pattern");
  // Data phase flag lands on the alignment end edge, so frame 0 leaves the output flops one edge later
  a_ilas_start: assert property (
    up && ilas_done_i && link_running_i && long_on && !frame_valid_o |-> ##2 pattern_start_o && frame_valid_o)
    else $error("pattern did not follow alignment");
  a_frame0_conv: assert property (s_pat_start |-> w0 == 16'h1)
    else $error("frame 0 converter value wrong");
  a_frame1_smp: assert property (s_pat_start ##1 link_running_i |-> w0 == 16'h1)
    else $error("frame 1 sample value wrong");
  a_frame2_mid: assert property (s_pat_start ##1 link_running_i [*2] |-> w0 == (16'h1 << (cfg_n_i - 5'h1)))
    else $error("frame 2 mid value wrong");
  a_d215_char: assert property (up && sel == 4'h4 |=> char_o == 8'hb5 && !char_k_o)
    else $error("D21.5 stream broken");
  a_k285_char: assert property (up && sel == 4'h5 |=> char_o == 8'hbc && char_k_o)
    else $error("K28.5 stream broken");
  a_rpat_order: assert property (
    s_rpat_enter ##1 sel == 4'h7 |=> char_o == 8'hd7 && $past(char_o) == 8'hbe)
    else $error("RPAT start order wrong");
  a_ila_no_data: assert property (up && sel == 4'h6 |=> !data_phase_en_o)
    else $error("data phase in repeated alignment");
  a_sync_cgs: assert property (up && sel == 4'h6 && link_running_i && !sync_b_i |-> ##[1:6] cgs_req_o)
    else $error("no code group sync on request");
endmodule

//--- tb/sltpg_rx_model.sv
// Behavioural serial receiver: sync request and link layer status
`timescale 1ns/10ps
module sltpg_rx_model (
  input  wire logic clk_sys_i,
  input  wire logic link_running_i,
  input  wire logic sync_req_i,
  input  wire logic frame_valid_i,
  input  wire logic cgs_req_i,
  output logic      sync_b_o,
  output logic      cgs_done_o,
  output logic      ilas_done_o
);
  logic [1:0] ila_cnt_q;
  // Request is active low on the pin
  assign sync_b_o = !sync_req_i;
  // Sync only completes once the request is withdrawn
  always_ff @(posedge clk_sys_i)
    cgs_done_o <= cgs_req_i && !sync_req_i;
  // Alignment ends every fourth frame, never during data phase
  always_ff @(posedge clk_sys_i) begin
    ila_cnt_q <= (link_running_i && !cgs_req_i && !frame_valid_i) ? ila_cnt_q + 2'h1 : 2'h0;
    ilas_done_o <= link_running_i && !cgs_req_i && !frame_valid_i && ila_cnt_q == 2'h3;
  end
endmodule

//--- tb/tb_serial_link_test_pattern_gen.sv
// Self-checking bench for the test pattern generator
`timescale 1ns/10ps
module tb_serial_link_test_pattern_gen;
  logic         clk_sys_i, rst_b_i, cs, run, sync_req;
  logic [3:0]   sel;
  logic [4:0]   fmt, np, n;
  logic [2:0]   m, s;
  logic [5:0]   k;
  logic [255:0] data_a, data_b, fa, fb;
  logic [7:0]   ch;
  logic         fv, pst, sgl, ck, csel, dpe, cgsq, ilr, sb, cgd, ild;
  int           fail_count, n_compared, cyc;

  sltpg_top i_dut (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link_test_pattern_select_i(sel), .link_format_select_i(fmt),
    .cfg_np_i(np), .cfg_m_i(m), .cfg_s_i(s), .cfg_k_i(k), .cfg_n_i(n), .cfg_cs_i(cs), .link_running_i(run),
    .ilas_done_i(ild), .cgs_done_i(cgd), .sync_b_i(sb), .data_a_i(data_a), .data_b_i(data_b),
    .frame_a_o(fa), .frame_b_o(fb), .frame_valid_o(fv), .pattern_start_o(pst), .single_link_o(sgl),
    .char_o(ch), .char_k_o(ck), .char_sel_o(csel), .data_phase_en_o(dpe), .cgs_req_o(cgsq),
    .ilas_restart_o(ilr));
  sltpg_rx_model i_rx (.clk_sys_i(clk_sys_i), .link_running_i(run), .sync_req_i(sync_req),
    .frame_valid_i(fv), .cgs_req_i(cgsq), .sync_b_o(sb), .cgs_done_o(cgd), .ilas_done_o(ild));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Hang guard, well beyond the roughly 150 cycles needed
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic tick(input int c = 1);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Reference frame i of the long pattern for the current config
  function automatic logic [255:0] exp_frame(input int i);
    logic [255:0] f;
    logic [15:0]  w;
    f = '0;
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 4; j++) begin
        w = (i == 0) ? 16'(c + 1) : (i == 1) ? 16'(j + 1) : (16'h1 << (n - 5'h1));
        w = w << (5'h10 - n);
        if (cs && n < 5'h10 && i == c * s + j && j < s)
          w[15 - n] = 1'b1;
        if (c < m && j < s)
          f[(c * 4 + j) * 16 +: 16] = w;
      end
    end
    return f;
  endfunction

  task automatic t_pass(input logic [3:0] sl, input logic [4:0] p);
    sel = sl;
    np = p;
    run = 1'b1;
    tick(2);
    for (int i = 0; i < 4; i++) begin
      data_a = {64{4'(i + 3)}};
      data_b = ~data_a;
      tick();
      chk("pass A", fa, data_a);
      chk("pass B", fb, data_b);
    end
    run = 1'b0;
    tick(3);
    $display("pass-through mode %0d done", sl);
  endtask
  task automatic t_long(input logic [4:0] fm, input logic [4:0] nn, input logic [2:0] mm,
                        input logic [2:0] ss, input logic [5:0] kk, input logic c);
    int len;
    {fmt, n, m, s, k, cs, np, sel} = {fm, nn, mm, ss, kk, c, 5'h10, 4'h1};
    len = kk * ((mm * ss + 2 + kk - 1) / kk);
    tick(2);
    run = 1'b1;
    for (int t = 0; t < 40 && pst !== 1'b1; t++) tick();
    chk("single link", sgl, fm == 5'h0f);
    for (int i = 0; i <= len; i++) begin
      chk("frame A", fa, exp_frame(i % len));
      chk("frame B", fb, exp_frame(i % len));
      tick();
    end
    run = 1'b0;
    tick(3);
    $display("long pattern format %0d done", fm);
  endtask
  task automatic t_chars;
    logic [95:0] rp;
    rp = 96'hbed723476b8fb3145efb3559;
    sel = 4'h4;
    tick(2);
    chk("D21.5", {ck, ch}, 9'h0b5);
    sel = 4'h5;
    tick(2);
    chk("K28.5", {ck, csel, ch}, 10'h3bc);
    sel = 4'h7;
    tick();
    for (int i = 0; i < 26; i++) begin
      chk("RPAT", ch, rp[95 - 8 * (i % 12) -: 8]);
      tick();
    end
    $display("character modes done");
  endtask
  task automatic t_ila;
    sel = 4'h6;
    sync_req = 1'b1;
    run = 1'b1;
    tick(3);
    chk("cgs start", cgsq, 1'b1);
    sync_req = 1'b0;
    for (int t = 0; t < 12 && cgsq !== 1'b0; t++) tick();
    for (int t = 0; t < 12 && ilr !== 1'b1; t++) tick();
    chk("alignment restart", ilr, 1'b1);
    chk("no data phase", dpe, 1'b0);
    sync_req = 1'b1;
    for (int t = 0; t < 8 && cgsq !== 1'b1; t++) tick();
    chk("resync", cgsq, 1'b1);
    {sync_req, run, sel} = '0;
    tick(4);
    $display("repeated alignment done");
  endtask
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {rst_b_i, cs, run, sync_req, sel, fmt, np, n, m, s, k, data_a, data_b} = '0;
    {fail_count, n_compared, cyc} = '0;
    repeat (5) @(posedge clk_sys_i);
    #1 rst_b_i = 1'b1;
    tick(5);
    t_pass(4'h0, 5'h10);
    t_pass(4'h1, 5'h0c);
    t_long(5'h0a, 5'h0f, 3'h2, 3'h1, 6'h2, 1'b1);
    t_long(5'h0f, 5'h0c, 3'h4, 3'h2, 6'h3, 1'b1);
    t_long(5'h0a, 5'h10, 3'h2, 3'h1, 6'ha, 1'b0);
    t_chars();
    t_ila();
    test_done();
  end
endmodule

bind sltpg_top sltpg_monitor i_mon (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link_test_pattern_select_i(link_test_pattern_select_i),
  .cfg_np_i(cfg_np_i), .cfg_n_i(cfg_n_i), .link_running_i(link_running_i), .ilas_done_i(ilas_done_i),
  .sync_b_i(sync_b_i), .data_a_i(data_a_i), .frame_a_o(frame_a_o), .frame_b_o(frame_b_o),
  .frame_valid_o(frame_valid_o), .pattern_start_o(pattern_start_o), .char_o(char_o), .char_k_o(char_k_o),
  .data_phase_en_o(data_phase_en_o), .cgs_req_o(cgs_req_o));
